//--- hw/clk_gen_params.svh
// Purpose: Offsets, field positions, reset values and widths of the
//          system clock source and prescaler block.
// Assumes: 32-bit register words on a plain strobe port.
// Notes:   Definitions only.
`ifndef CLK_GEN_PARAMS_SVH
`define CLK_GEN_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SYS_CTRL 4'h0
`define OFS_PLL_CTRL 4'h4
`define OFS_PRESCALE 4'h8
`define OFS_STATUS 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEL_LSB 0
`define BYP_BIT 0
`define OSC_INT_BIT 1
`define REFDIV_LSB 4
`define MULT_LSB 8
`define OUTDIV_LSB 16
`define PRESC_LSB 0

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define PRESC_W 10
`define REFDIV_W 4
`define MULT_W 7
`define OUTDIV_W 7

// ----------------------------------------------------------------
// Source select codes and reset values
// ----------------------------------------------------------------
`define SEL_WAKEUP 2'h0
`define SEL_PLL 2'h2
`define SEL_DIRECT 2'h3
`define RST_SEL 2'h0
`define RST_BYP 1'h1
`define RST_OSC_INT 1'h1
`define RST_PRESC 10'h000
`define RST_REFDIV 4'h0
`define RST_MULT 7'h00
`define RST_OUTDIV 7'h00

`endif

//--- hw/clk_gen_pkg.sv
// Purpose: Types shared by the clock source block.
// Assumes: Nothing.
// Notes:   Constants live in clk_gen_params.svh.
package clk_gen_pkg;

  // ----------------------------------------------------------------
  // Source switch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RUN_S,
    DRAIN_S,
    HOLD_S
  } switch_state_t;

endpackage : clk_gen_pkg

//--- hw/level_divider.sv
// Purpose: Divides a sampled clock level by a programmable factor.
// Assumes: Input level is already synchronised to clk.
// Notes:   Factor is div+1; toggles every div+1 input half periods.
`timescale 1ns/1ps
module level_divider #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [W-1:0] div,
  // Levels
  input wire logic lvl,
  output logic out_r
);

  logic prev_r; // Last seen input level
  logic [W-1:0] cnt_r; // Half periods since last toggle
  logic edge_s; // Input changed

  assign edge_s = lvl != prev_r;

  // ----------------------------------------------------------------
  // Edge tracking
  // ----------------------------------------------------------------
  // Cleared to low so a high input shows up as a fresh edge
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  // ----------------------------------------------------------------
  // Half period counter and output toggle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (edge_s) begin
      if (cnt_r == div) begin // Factor reached
        cnt_r <= '0;
        out_r <= ~out_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  toggle_at_factor_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clear && $changed(out_r) && !$past(clear) |-> $past(cnt_r) == $past(div))
    else $error("divider toggled before its factor");
  unit_factor_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clear && div == '0 |=> $past(clear) || out_r == $past(lvl))
    else $error("factor one does not follow input");
  count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clear |-> cnt_r <= div)
    else $error("divider count above factor");

endmodule : level_divider

//--- hw/sys_clock_source.sv
// Purpose: Selects and generates the system clock level from pin clocks.
// Assumes: Pin clocks are far slower than clk and sampled by it.
// Notes:   Source or divider changes pass through a low-hold sequence.
//
// Behaviour
// - select 11 drives system clock from direct input
// - direct mode keeps input duty cycle
// - select 10 with bypass set is prescaler
// - prescaler input is crystal or internal source
// - prescaler output is oscillator over field plus one
// - factor one passes oscillator unchanged
// - prescale factor reaches 1024
// - select 10 without bypass enables PLL path
// - select 00 runs from wakeup clock
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "clk_gen_params.svh"
module sys_clock_source
  import clk_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data_r,
  // Clock pins
  input wire logic direct_clock_input,
  input wire logic crystal_input,
  input wire logic internal_clock_input,
  input wire logic wakeup_clock_input,
  input wire logic pll_vco_input,
  // PLL control
  output logic pll_enable_r,
  output logic pll_ref_clock,
  output logic [`MULT_W-1:0] pll_multiply_r,
  // System clock
  output logic sys_clock_r,
  output logic switch_busy_r
);

  localparam int NP = 5; // Synchronised pins
  localparam int HOLD_MAX = 1000; // Longest wait for a low divider input

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NP-1:0] pins; // Raw pin levels
  logic [NP-1:0] s1_r, s2_r, s3_r; // Three-stage samplers
  logic [NP-1:0] lvl_r; // Accepted levels
  logic dir_lvl, xtal_lvl, int_lvl, wu_lvl, vco_lvl;
  logic [1:0] clock_source_select; // Software select
  logic oscillator_bypass_select; // Software bypass
  logic osc_int_r; // Oscillator from internal source
  logic [`PRESC_W-1:0] prescaler_divide_field;
  logic [`REFDIV_W-1:0] pll_input_divide_field;
  logic [`MULT_W-1:0] pll_multiply_field;
  logic [`OUTDIV_W-1:0] pll_output_divide_field;
  logic [1:0] act_sel_r; // Active select
  logic act_byp_r; // Active bypass
  logic act_int_r; // Active oscillator choice
  logic [`PRESC_W-1:0] act_presc_r;
  logic [`REFDIV_W-1:0] act_p_r;
  logic [`OUTDIV_W-1:0] act_outdiv_r;
  logic pending; // Software differs from active
  logic osc_lvl; // Selected oscillator level
  logic presc_out, outdiv_out; // Divider outputs
  logic div_in_lvl; // Input level of the active divider
  logic hold_ok; // Safe to leave the hold state
  logic src_lvl; // Chosen source level
  logic div_clear; // Restart dividers
  switch_state_t state_r;

  assign pins = {pll_vco_input, wakeup_clock_input, internal_clock_input,
                 crystal_input, direct_clock_input};
  assign dir_lvl = lvl_r[0];
  assign xtal_lvl = lvl_r[1];
  assign int_lvl = lvl_r[2];
  assign wu_lvl = lvl_r[3];
  assign vco_lvl = lvl_r[4];

  // ----------------------------------------------------------------
  // Pin samplers
  // ----------------------------------------------------------------
  // Level accepted once second and third stages agree
  for (genvar i = 0; i < NP; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        lvl_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pins[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clock_source_select <= `RST_SEL;
      oscillator_bypass_select <= `RST_BYP;
      osc_int_r <= `RST_OSC_INT;
      prescaler_divide_field <= `RST_PRESC;
      pll_input_divide_field <= `RST_REFDIV;
      pll_multiply_field <= `RST_MULT;
      pll_output_divide_field <= `RST_OUTDIV;
    end else if (wr_stb) begin
      case (addr)
        `OFS_SYS_CTRL: begin
          clock_source_select <= wr_data[`SEL_LSB +: 2];
        end
        `OFS_PLL_CTRL: begin
          oscillator_bypass_select <= wr_data[`BYP_BIT];
          osc_int_r <= wr_data[`OSC_INT_BIT];
          pll_input_divide_field <= wr_data[`REFDIV_LSB +: `REFDIV_W];
          pll_multiply_field <= wr_data[`MULT_LSB +: `MULT_W];
          pll_output_divide_field <= wr_data[`OUTDIV_LSB +: `OUTDIV_W];
        end
        `OFS_PRESCALE: begin
          prescaler_divide_field <= wr_data[`PRESC_LSB +: `PRESC_W];
        end
        default: begin
          // Status and unmapped: write ignored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !rd_stb) begin
      rd_data_r <= 32'h0;
    end else begin
      rd_data_r <= 32'h0;
      case (addr)
        `OFS_SYS_CTRL: begin
          rd_data_r[`SEL_LSB +: 2] <= clock_source_select;
        end
        `OFS_PLL_CTRL: begin
          rd_data_r[`BYP_BIT] <= oscillator_bypass_select;
          rd_data_r[`OSC_INT_BIT] <= osc_int_r;
          rd_data_r[`REFDIV_LSB +: `REFDIV_W] <= pll_input_divide_field;
          rd_data_r[`MULT_LSB +: `MULT_W] <= pll_multiply_field;
          rd_data_r[`OUTDIV_LSB +: `OUTDIV_W] <= pll_output_divide_field;
        end
        `OFS_PRESCALE: begin
          rd_data_r[`PRESC_LSB +: `PRESC_W] <= prescaler_divide_field;
        end
        `OFS_STATUS: begin
          rd_data_r[4:0] <= {sys_clock_r, switch_busy_r, act_byp_r, act_sel_r};
        end
        default: begin
          rd_data_r <= 32'h0; // Unmapped reads zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Source and divider selection
  // ----------------------------------------------------------------
  assign pending = {clock_source_select, oscillator_bypass_select, osc_int_r,
                    prescaler_divide_field, pll_input_divide_field,
                    pll_output_divide_field} !=
                   {act_sel_r, act_byp_r, act_int_r, act_presc_r, act_p_r, act_outdiv_r};
  assign osc_lvl = act_int_r ? int_lvl : xtal_lvl;
  assign div_clear = state_r == HOLD_S;
  // Divider input must be low when its clear lifts, so no phase starts short
  assign div_in_lvl = act_byp_r ? osc_lvl : vco_lvl;
  assign hold_ok = !src_lvl && !(act_sel_r == `SEL_PLL && div_in_lvl);

  always_comb begin
    case (act_sel_r)
      `SEL_DIRECT: src_lvl = dir_lvl; // Passed straight
      `SEL_PLL: src_lvl = act_byp_r ? presc_out : outdiv_out;
      default: src_lvl = wu_lvl; // Wakeup, reserved code too
    endcase
  end

  // Oscillator prescaler
  level_divider #(.W(`PRESC_W)) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(div_clear),
    .div(act_presc_r),
    .lvl(osc_lvl),
    .out_r(presc_out)
  );

  // PLL reference divider
  level_divider #(.W(`REFDIV_W)) u_p (
    .clk(clk),
    .rst_n(rst_n),
    .clear(div_clear),
    .div(act_p_r),
    .lvl(osc_lvl),
    .out_r(pll_ref_clock)
  );

  // PLL output divider
  level_divider #(.W(`OUTDIV_W)) u_outdiv (
    .clk(clk),
    .rst_n(rst_n),
    .clear(div_clear),
    .div(act_outdiv_r),
    .lvl(vco_lvl),
    .out_r(outdiv_out)
  );

  // ----------------------------------------------------------------
  // Switch sequencer: finish high phase, hold low, restart
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= RUN_S;
    end else begin
      case (state_r)
        RUN_S: if (pending) state_r <= DRAIN_S;
        DRAIN_S: if (!src_lvl) state_r <= HOLD_S; // High phase done
        HOLD_S: if (hold_ok) state_r <= RUN_S; // Restart on a low input
        default: state_r <= RUN_S;
      endcase
    end
  end

  // Active configuration taken over only while output is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_sel_r <= `RST_SEL;
      act_byp_r <= `RST_BYP;
      act_int_r <= `RST_OSC_INT;
      act_presc_r <= `RST_PRESC;
      act_p_r <= `RST_REFDIV;
      act_outdiv_r <= `RST_OUTDIV;
    end else if (state_r == DRAIN_S && !src_lvl) begin
      act_sel_r <= clock_source_select;
      act_byp_r <= oscillator_bypass_select;
      act_int_r <= osc_int_r;
      act_presc_r <= prescaler_divide_field;
      act_p_r <= pll_input_divide_field;
      act_outdiv_r <= pll_output_divide_field;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_clock_r <= 1'b0;
      switch_busy_r <= 1'b0;
    end else begin
      sys_clock_r <= (state_r == HOLD_S) ? 1'b0 : src_lvl;
      switch_busy_r <= state_r != RUN_S;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_enable_r <= 1'b0;
      pll_multiply_r <= `RST_MULT;
    end else begin
      pll_enable_r <= act_sel_r == `SEL_PLL && !act_byp_r;
      pll_multiply_r <= pll_multiply_field;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence steady_s(logic [1:0] sel);
    state_r == RUN_S && act_sel_r == sel && !pending;
  endsequence

  direct_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    steady_s(`SEL_DIRECT) |=> sys_clock_r == $past(dir_lvl))
    else $error("direct mode not following input");
  direct_duty_a: assert property (@(posedge clk) disable iff (!rst_n)
    steady_s(`SEL_DIRECT) ##1 steady_s(`SEL_DIRECT) ##0 $rose(dir_lvl)
    |=> $rose(sys_clock_r))
    else $error("direct mode reshapes input");
  prescale_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    steady_s(`SEL_PLL) ##0 act_byp_r |=> sys_clock_r == $past(presc_out))
    else $error("prescaler path not selected");
  osc_choice_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(act_int_r) |-> $past(state_r) == DRAIN_S && $past(osc_int_r))
    else $error("oscillator choice changed outside switch");
  pll_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    steady_s(`SEL_PLL) ##1 state_r == RUN_S |-> pll_enable_r == !$past(act_byp_r))
    else $error("pll enable does not match mode");
  wakeup_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    steady_s(`SEL_WAKEUP) |=> sys_clock_r == $past(wu_lvl))
    else $error("wakeup mode not following source");
  switch_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == DRAIN_S && !src_lvl |=> state_r == HOLD_S ##1 !sys_clock_r)
    else $error("system clock not held low across switch");
  switch_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == HOLD_S |-> ##[1:HOLD_MAX] state_r == RUN_S)
    else $error("switch sequence stuck");

endmodule : sys_clock_source

//--- dv/clk_pins_model.sv
// Purpose: Free-running clock sources seen at the block's clock pins.
// Assumes: Phases are whole clk cycles, at least 2 each.
// Notes:   Pin order: direct, crystal, internal, wakeup, PLL VCO.
`timescale 1ns/1ps
module clk_pins_model #(
  parameter int HI [5] = '{5, 3, 3, 40, 2},
  parameter int LO [5] = '{9, 3, 5, 40, 2}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels
  output logic [4:0] pins_r
);
  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 5; g++) begin : g_osc
    int cnt; // Cycles left in the current phase
    // Oscillators run free, so each pin keeps toggling whenever rst_n is high
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pins_r[g] <= 1'b0;
        cnt <= LO[g] - 1;
      end else if (cnt == 0) begin
        pins_r[g] <= ~pins_r[g];
        cnt <= (pins_r[g] ? LO[g] : HI[g]) - 1;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : clk_pins_model

//--- dv/tb_sys_clock_source.sv
// Purpose: Self-checking bench of the system clock source block.
// Assumes: Pin phases from clk_pins_model defaults.
// Notes:   Phase lengths of sys_clock_r are counted in clk cycles.
`timescale 1ns/1ps
`include "clk_gen_params.svh"
module tb_sys_clock_source;
  import clk_gen_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // Sampling clock
  logic rst_n = 1'b0; // Active low reset
  logic [3:0] addr = 4'h0; // Register offset
  logic [31:0] wr_data = 32'h0; // Write data
  logic wr_stb = 1'b0; // Write strobe
  logic rd_stb = 1'b0; // Read strobe
  logic [31:0] rd_data_r; // Read data
  logic [4:0] pins; // Model pin levels
  logic pll_enable_r; // PLL enable
  logic pll_ref_clock; // PLL reference
  logic [`MULT_W-1:0] pll_multiply_r; // PLL N field
  int nref; // High cycles of the PLL reference in a window
  logic sys_clock_r; // Generated clock
  logic switch_busy_r; // Switch in progress
  int n_fail = 0; // Mismatch count
  int compares = 0; // Comparison count
  logic [31:0] d; // Read scratch
  int run = 0; // Cycles in current sys_clock_r phase
  logic last = 1'b0; // Previous sys_clock_r level
  // Scenario table: select, 0x4 word, divide field, expected high, low
  logic [1:0] t_sel [6] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0};
  logic [31:0] t_pll [6] = '{32'h3, 32'h3, 32'h1, 32'h1, 32'h00010502, 32'h3};
  logic [9:0] t_presc [6] = '{10'h000, 10'h000, 10'h002, 10'h3ff, 10'h000, 10'h000};
  int t_hi [6] = '{5, 3, 9, 3072, 4, 40};
  int t_lo [6] = '{9, 5, 9, 3072, 4, 40};

  // Clock at 250 MHz
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  clk_pins_model i_clk_pins_model (.clk(clk), .rst_n(rst_n), .pins_r(pins));
  sys_clock_source i_sys_clock_source (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_r(rd_data_r), .direct_clock_input(pins[0]),
    .crystal_input(pins[1]), .internal_clock_input(pins[2]),
    .wakeup_clock_input(pins[3]), .pll_vco_input(pins[4]),
    .pll_enable_r(pll_enable_r), .pll_ref_clock(pll_ref_clock),
    .pll_multiply_r(pll_multiply_r), .sys_clock_r(sys_clock_r),
    .switch_busy_r(switch_busy_r));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One-cycle write
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Read; data stands one cycle, then 0
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rd_data_r;
    @(posedge clk);
    #1 check("rd_idle", rd_data_r, 32'h0);
  endtask : rd
  // Wait until no switch for 16 cycles in a row
  task automatic settle();
    int quiet;
    int t;
    quiet = 0;
    t = 0;
    while (quiet < 16 && t < 20000) begin
      @(posedge clk);
      #1 quiet = (switch_busy_r === 1'b0) ? quiet + 1 : 0;
      t++;
    end
    if (quiet < 16) check("settle", 32'h0, 32'h1);
  endtask : settle
  // Count cycles until sys_clock_r shows level v
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (sys_clock_r !== v && n < 8000);
    if (n >= 8000) check("sys_clock_stuck", 32'h0, 32'h1);
  endtask : wait_lvl
  // Measure one high and one low phase
  task automatic meas(input int eh, input int el);
    int t;
    int h;
    int l;
    wait_lvl(1'b0, t);
    wait_lvl(1'b1, t);
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, l);
    check("sys_clock_high", 32'(h), 32'(eh));
    check("sys_clock_low", 32'(l), 32'(el));
  endtask : meas
  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  // No sys_clock_r phase may be shorter than two cycles, switches included
  always @(posedge clk) begin
    #1;
    if (rst_n !== 1'b1) run = 0;
    else if (sys_clock_r !== last) begin
      if (run > 0) check("phase_len", 32'(run >= 2), 32'h1);
      run = 1;
    end else if (run > 0) run++;
    last = sys_clock_r;
  end

  // Watchdog
  initial begin
    #320000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h4, d);
    check("pll_ctrl_reset", d, 32'h3);
    rd(4'h0, d);
    check("sys_ctrl_reset", d, 32'h0);
    rd(4'h8, d);
    check("prescale_reset", d, 32'h0);
    rd(4'hc, d);
    check("status_reset", {28'h0, d[3:0]}, 32'h4);
    meas(40, 40);
    for (int i = 0; i < 6; i++) begin
      wr(4'h4, t_pll[i]);
      wr(4'h8, {22'h0, t_presc[i]});
      wr(4'h0, {30'h0, t_sel[i]});
      settle();
      rd(4'hc, d);
      check("status_active", {28'h0, d[3:0]}, {29'h0, t_pll[i][0], t_sel[i]});
      check("pll_enable", {31'h0, pll_enable_r},
            {31'h0, t_sel[i] == 2'h2 && !t_pll[i][0]});
      if (pll_enable_r === 1'b1) begin
        check("pll_multiply", {25'h0, pll_multiply_r}, {25'h0, t_pll[i][14:8]});
        // Reference divide factor one: internal source, 3 high in each 8
        nref = 0;
        repeat (16) begin
          @(posedge clk);
          #1 nref += int'(pll_ref_clock === 1'b1);
        end
        check("pll_ref_clock", 32'(nref), 32'h6);
      end
      meas(t_hi[i], t_lo[i]);
    end
    wr(4'hc, 32'hf);
    rd(4'hc, d);
    check("status_ro", {28'h0, d[3:0]}, 32'h4);
    check("busy_ro", {31'h0, switch_busy_r}, 32'h0);
    rd(4'h2, d);
    check("unmapped", d, 32'h0);
    rd(4'h8, d);
    check("prescale_keep", d, 32'h0);
    end_of_test();
  end
endmodule : tb_sys_clock_source
